/* File: src/sys_functions_pkg.sv */
// constants shared by the system functions block
package sys_functions_pkg;

    // ****************************************
    // i/o bus geometry
    // ****************************************
    localparam int IO_ADDR_W = 16;
    localparam int IO_DATA_W = 8;
    localparam int WIN_OFFS_W = 6; // 64-byte window
    localparam logic [7:0] WIN_HIGH_BYTE = 8'h00; // window lives in 0x0000-0x00FF

    // ****************************************
    // register offsets inside the window
    // ****************************************
    localparam logic [5:0] OFFS_FREE_RUN_COUNT = 6'h18;
    localparam logic [5:0] OFFS_IO_WINDOW_CONTROL = 6'h3F;
    localparam logic [5:0] OFFS_REFRESH_SLOT = 6'h36;

    // ****************************************
    // io_window_control fields
    // ****************************************
    localparam int WCTL_BASE_MSB = 7;
    localparam int WCTL_BASE_LSB = 6;
    localparam int WCTL_STOP_BIT = 5;
    localparam logic [4:0] WCTL_RSVD_READ = 5'h1F;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] FREE_RUN_COUNT_RST = 8'hFF;
    localparam logic [1:0] WIN_BASE_RST = 2'h0;
    localparam logic STOP_RST = 1'b0;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int FRC_DIVIDE = 10; // counter steps every tenth core clock

    // window select code to base address
    function automatic logic [7:0] win_base_addr(input logic [1:0] sel);
        win_base_addr = {sel, 6'h00};
    endfunction

endpackage

/* File: src/tick_link_if.sv */
// link between the counter block and its prescaler
`timescale 1ns/1ps
interface tick_link_if;
    logic halt;
    logic tick;

    modport owner (output halt, input tick);
    modport divider (input halt, output tick);
endinterface

/* File: src/clk_div_tick.sv */
// divide-by-n tick generator, frozen while halted
`timescale 1ns/1ps
module clk_div_tick #(
    parameter int DIVIDE = sys_functions_pkg::FRC_DIVIDE
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // tick link
    tick_link_if.divider link
);
    import sys_functions_pkg::*;

    localparam int CNT_W = $clog2(DIVIDE);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIVIDE - 1);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
    } div_state_type;

    div_state_type st_r;
    div_state_type st_nxt;

    // ****************************************
    // next state
    // ****************************************
    // count holds and no tick leaves while halted
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!link.halt) begin
            if (st_r.cnt == CNT_LAST) begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.tick = st_r.tick;

endmodule

/* File: src/io_relocation_free_counter.sv */
// relocatable i/o window, i/o stop control and free-running counter
`timescale 1ns/1ps

// Function
// RULE1: 8-bit counter, resets ones, decrements every tenth clock
// RULE2: control bits 7:6 pick 64-byte i/o range
// RULE3: all on-chip decode follows the chosen base
// RULE4: control bit 5 stops serial, timers, counter
// RULE5: control bits 4:0 always read as ones
// RULE6: no refresh; reserved slots stay unimplemented
// RULE7: writing counter loads new count, counting continues
module io_relocation_free_counter #(
    parameter int FRC_DIV = sys_functions_pkg::FRC_DIVIDE
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // i/o bus from the core
    input wire logic [sys_functions_pkg::IO_ADDR_W-1:0] io_addr_i,
    input wire logic [sys_functions_pkg::IO_DATA_W-1:0] io_wdata_i,
    input wire logic io_write_i,
    input wire logic io_read_i,
    // read answer for this block
    output logic [sys_functions_pkg::IO_DATA_W-1:0] io_rdata_o,
    output logic io_rack_o,
    // window decode for the other peripherals
    output logic io_win_hit_o,
    output logic [sys_functions_pkg::WIN_OFFS_W-1:0] io_win_offs_o,
    output logic io_win_write_o,
    output logic io_win_read_o,
    // i/o stop, window base and counter state
    output logic io_stop_o,
    output logic [7:0] win_base_o,
    output logic [7:0] free_run_count_o
);
    import sys_functions_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] frc;
        logic [1:0] base_sel;
        logic stop;
        logic [7:0] rdata;
        logic rack;
        logic hit;
        logic [5:0] offs;
        logic win_wr;
        logic win_rd;
    } sys_state_type;

    sys_state_type st_r;
    sys_state_type st_nxt;

    // decode helpers
    logic in_window;
    logic [5:0] offs;
    logic [7:0] ctl_read;
    logic frc_sel;
    logic ctl_sel;

    // ****************************************
    // prescaler
    // ****************************************
    tick_link_if tick_link ();

    // the divider freezes with the counter during i/o stop
    assign tick_link.halt = st_r.stop; // RULE4

    clk_div_tick #(
        .DIVIDE(FRC_DIV)
    ) u_div (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .link(tick_link.divider)
    );

    // ****************************************
    // address decode
    // ****************************************
    // upper byte must be zero and bits 7:6 must match the base
    assign in_window = (io_addr_i[15:8] == WIN_HIGH_BYTE) &&
                       (io_addr_i[7:6] == st_r.base_sel); // RULE2 RULE3
    assign offs = io_addr_i[5:0];
    assign frc_sel = in_window && (offs == OFFS_FREE_RUN_COUNT);
    assign ctl_sel = in_window && (offs == OFFS_IO_WINDOW_CONTROL);

    // control register image, reserved bits forced high
    assign ctl_read = {st_r.base_sel, st_r.stop, WCTL_RSVD_READ}; // RULE5

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;

        // counter: a write wins over the tick of the same cycle
        if (io_write_i && frc_sel) begin
            st_nxt.frc = io_wdata_i; // RULE7
        end else if (tick_link.tick && !st_r.stop) begin
            st_nxt.frc = st_r.frc - 8'h01; // RULE1 RULE4
        end

        // window control: base and stop bits are writable
        if (io_write_i && ctl_sel) begin
            st_nxt.base_sel = io_wdata_i[WCTL_BASE_MSB:WCTL_BASE_LSB]; // RULE2
            st_nxt.stop = io_wdata_i[WCTL_STOP_BIT]; // RULE4
        end

        // read answer, one cycle after the strobe
        st_nxt.rack = io_read_i && (frc_sel || ctl_sel);
        st_nxt.rdata = READ_IDLE;
        if (io_read_i && frc_sel) begin
            st_nxt.rdata = st_r.frc; // RULE1
        end else if (io_read_i && ctl_sel) begin
            st_nxt.rdata = ctl_read; // RULE5
        end
        // refresh slot and other reserved offsets give no answer here
        // RULE6

        // decode handed on to the other peripherals
        st_nxt.hit = in_window && (io_read_i || io_write_i); // RULE3
        st_nxt.offs = in_window ? offs : 6'h00;
        st_nxt.win_wr = in_window && io_write_i;
        st_nxt.win_rd = in_window && io_read_i;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r.frc <= FREE_RUN_COUNT_RST; // RULE1
            st_r.base_sel <= WIN_BASE_RST;
            st_r.stop <= STOP_RST;
            st_r.rdata <= READ_IDLE;
            st_r.rack <= 1'b0;
            st_r.hit <= 1'b0;
            st_r.offs <= 6'h00;
            st_r.win_wr <= 1'b0;
            st_r.win_rd <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // all straight from the state register
    assign io_rdata_o = st_r.rdata;
    assign io_rack_o = st_r.rack;
    assign io_win_hit_o = st_r.hit;
    assign io_win_offs_o = st_r.offs;
    assign io_win_write_o = st_r.win_wr;
    assign io_win_read_o = st_r.win_rd;
    assign io_stop_o = st_r.stop; // RULE4
    assign win_base_o = win_base_addr(st_r.base_sel);
    assign free_run_count_o = st_r.frc;

endmodule

/* File: testbench/io_relocation_free_counter_sva.sv */
// checker for the i/o window, stop control and free-running counter
`timescale 1ns/1ps
module io_relocation_free_counter_sva #(
    parameter int FRC_DIV = 10
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // bus from the core
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_write_i,
    input wire logic io_read_i,
    // answers and state
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rack_o,
    input wire logic io_win_hit_o,
    input wire logic [5:0] io_win_offs_o,
    input wire logic io_win_write_o,
    input wire logic io_win_read_o,
    input wire logic io_stop_o,
    input wire logic [7:0] win_base_o,
    input wire logic [7:0] free_run_count_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // decode of own registers under the current base
    wire logic [15:0] cnt_a = {8'h00, win_base_o[7:6], 6'h18};
    wire logic [15:0] ctl_a = {8'h00, win_base_o[7:6], 6'h3F};
    wire logic in_win = io_addr_i[15:6] == {8'h00, win_base_o[7:6]};
    wire logic acc = io_read_i || io_write_i;
    wire logic cnt_wr = io_write_i && io_addr_i == cnt_a;
    wire logic ctl_wr = io_write_i && io_addr_i == ctl_a;
    sequence s_ctl_rd;
        io_read_i && !io_write_i && io_addr_i == ctl_a;
    endsequence
    a_cnt_read:
        assert property (io_read_i && !io_write_i && io_addr_i == cnt_a |=>
            io_rack_o && io_rdata_o == $past(free_run_count_o)) else $error("counter read wrong");
    a_cnt_step:
        assert property ($changed(free_run_count_o) && !$past(cnt_wr) |->
            free_run_count_o == $past(free_run_count_o) - 8'h01) else $error("counter step wrong");
    a_ctl_write:
        assert property (ctl_wr |=> win_base_o == ($past(io_wdata_i) & 8'hC0)
            && io_stop_o == |($past(io_wdata_i) & 8'h20)) else $error("control write wrong");
    a_out_win:
        assert property (acc && !in_win |=> !io_win_hit_o && !io_rack_o) else $error("hit outside window");
    a_in_win:
        assert property (acc && in_win |=> io_win_hit_o) else $error("window hit missing");
    a_win_decode:
        assert property (acc && in_win |=> io_win_offs_o == $past(io_addr_i[5:0])
            && io_win_write_o == $past(io_write_i) && io_win_read_o == $past(io_read_i))
            else $error("window decode wrong");
    a_stop_hold:
        assert property (io_stop_o && !cnt_wr |=> $stable(free_run_count_o)) else $error("counter ran in stop");
    a_ctl_read:
        assert property (s_ctl_rd |=> io_rack_o
            && io_rdata_o == ($past(win_base_o) | {2'h0, $past(io_stop_o), 5'h1F})) else $error("control read wrong");
    a_rsvd_quiet:
        assert property (io_read_i && in_win && io_addr_i[5:0] == 6'h36 |=> !io_rack_o && io_rdata_o == 8'h00)
            else $error("reserved slot answered");
    a_cnt_load:
        assert property (cnt_wr |=> free_run_count_o == $past(io_wdata_i)) else $error("counter load wrong");
endmodule
bind io_relocation_free_counter io_relocation_free_counter_sva #(.FRC_DIV(FRC_DIV)) u_sva (.*);

/* File: testbench/io_cpu_model.sv */
// processor-side model issuing single i/o reads and writes
`timescale 1ns/1ps
module io_cpu_model (
    // clock
    input wire logic clk_sys_i,
    // requests toward the block
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o,
    output logic write_o,
    output logic read_o
);
    // idle bus at time zero
    initial begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        write_o = 1'b0;
        read_o = 1'b0;
    end
    // one-cycle write, then lines scrambled so stale values never look valid
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        wdata_o <= d;
        write_o <= 1'b1;
        @(posedge clk_sys_i);
        write_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    // one-cycle read; the answer is settled 1 ns after the return edge
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys_i);
        addr_o <= a;
        read_o <= 1'b1;
        @(posedge clk_sys_i);
        read_o <= 1'b0;
        addr_o <= ~a;
        #1;
    endtask
endmodule

/* File: testbench/io_relocation_free_counter_tb.sv */
// self-checking bench for the i/o window and free-running counter
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module io_relocation_free_counter_tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, wb, cnt;
    logic io_write, io_read, io_rack, io_hit, io_stop;
    logic [1:0] cur;
    logic [5:0] io_offs;
    logic io_wrd;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    // clock
    always #25 clk_sys_i = ~clk_sys_i;
    io_relocation_free_counter #(.FRC_DIV(3)) u_io_relocation_free_counter (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_write_i(io_write), .io_read_i(io_read),
        .io_rdata_o(io_rdata), .io_rack_o(io_rack), .io_win_hit_o(io_hit), .io_win_offs_o(io_offs), .io_win_write_o(),
        .io_win_read_o(io_wrd), .io_stop_o(io_stop), .win_base_o(wb), .free_run_count_o(cnt));
    io_cpu_model u_io_cpu_model (.clk_sys_i(clk_sys_i), .addr_o(io_addr), .wdata_o(io_wdata),
        .write_o(io_write), .read_o(io_read));
    // verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        `CHK({io_stop, wb, cnt}, 17'h000FF)
        u_io_cpu_model.rd(16'h003F);
        `CHK({io_rack, io_rdata}, 9'h11F)
        $display("test reset done");
        u_io_cpu_model.wr(16'h003F, 8'h20);
        u_io_cpu_model.wr(16'h0018, 8'h5A);
        repeat (10) @(negedge clk_sys_i);
        `CHK({io_stop, cnt}, 9'h15A)
        u_io_cpu_model.rd(16'h0018);
        `CHK({io_rack, io_rdata}, 9'h15A)
        u_io_cpu_model.wr(16'h003F, 8'h00);
        repeat (13) @(negedge clk_sys_i);
        `CHK((8'h5A - cnt) >> 1, 8'h02)
        $display("test stop and count done");
        cur = 2'h0;
        for (int i = 0; i < 4; i++) begin
            u_io_cpu_model.wr({8'h00, cur, 6'h3F}, {i[1:0], 6'h00});
            u_io_cpu_model.rd({8'h00, cur, 6'h3F});
            if (i[1:0] != cur) `CHK({io_rack, io_hit}, 2'b00)
            cur = i[1:0];
            `CHK(wb, {cur, 6'h00})
            u_io_cpu_model.rd({8'h00, cur, 6'h3F});
            `CHK(io_rdata, {cur, 6'h1F})
            u_io_cpu_model.rd({8'h00, cur, 6'h36});
            `CHK({io_hit, io_wrd, io_offs, io_rack, io_rdata}, 17'h1EC00)
        end
        u_io_cpu_model.rd(16'h01FF);
        `CHK({io_rack, io_hit}, 2'b00)
        $display("test relocation done");
        results();
    end
endmodule
